/* pbclk_far_end.sv */
// Far end of port B: master clock sources and a frame clock receiver.
// Assumes the generator's frame, bit and frame enable pins are wired in.
`timescale 1ns/100ps
module pbclk_far_end (
  // Port B clocks
  input wire logic frame_in,
  input wire logic bit_in,
  input wire logic oe_in,
  // Master clocks and counts
  output logic [2:0] mclk_out = 3'h0,
  output logic [7:0] hi_out = 8'h00,
  output logic [7:0] frames_out = 8'h00
);
  logic [7:0] n = 8'h00;
  always #50 mclk_out[0] = ~mclk_out[0];
  always #70 mclk_out[1] = ~mclk_out[1];
  always #90 mclk_out[2] = ~mclk_out[2];
  // Bit clocks are taken in only while the port drives a high frame clock.
  always @(posedge bit_in) if (oe_in && frame_in) n <= n + 8'h01;
  always @(negedge frame_in) begin
    hi_out <= n;
    frames_out <= frames_out + 8'h01;
    n <= 8'h00;
  end
endmodule : pbclk_far_end

/* pbclk_params.svh */
// Constants for the port B master clock generator.
// Assumes inclusion by the package and the design modules only.
`ifndef PBCLK_PARAMS_SVH
`define PBCLK_PARAMS_SVH

`define PBCLK_REG_CLOCK_CONTROL 8'h06
`define PBCLK_DIV_LSB 0
`define PBCLK_DIV_MSB 1
`define PBCLK_SRC_LSB 2
`define PBCLK_SRC_MSB 3
`define PBCLK_DIV_RESET 2'h0
`define PBCLK_SRC_RESET 2'h0
`define PBCLK_BIT_PER_FRAME 64
`define PBCLK_BIT_HALF_LAST 5'h1f
`define PBCLK_SYNC_STAGES 2

`endif

/* pbclk_pkg.sv */
// Types shared by the port B master clock generator files.
// Assumes pbclk_params.svh sits in the same folder.
`include "pbclk_params.svh"

package pbclk_pkg;

  typedef enum logic [1:0] {
    DIV_128,
    DIV_256,
    DIV_384,
    DIV_512
  } frame_div_e;

  typedef enum logic [1:0] {
    SRC_MAIN_MCLK,
    SRC_RX_CLK_IN,
    SRC_RX_CLK_RECOVERED,
    SRC_RESERVED
  } mclk_src_e;

  typedef enum {
    GEN_IDLE,
    GEN_RUN
  } gen_state_e;

endpackage : pbclk_pkg

/* pbclk_props.sv */
// Assertions on the port B clock generator pins.
// Assumes it is bound to port_b_master_clock_gen.
`timescale 1ns/100ps
module pbclk_props (
  // Clock and reset
  input wire logic CLOCK_IN,
  input wire logic RESET_IN,
  // Register read side
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic REG_RD_IN,
  input wire logic [7:0] REG_RDATA_OUT,
  // Port B mode and clock pins
  input wire logic PORT_B_MASTER_SELECT_IN,
  input wire logic PORT_B_FRAME_CLOCK_OUT,
  input wire logic PORT_B_FRAME_CLOCK_OE_OUT,
  input wire logic PORT_B_BIT_CLOCK_OUT
);
  wire logic sel = PORT_B_MASTER_SELECT_IN;
  wire logic f = PORT_B_FRAME_CLOCK_OUT;
  wire logic oe = PORT_B_FRAME_CLOCK_OE_OUT;
  wire logic b = PORT_B_BIT_CLOCK_OUT;
  wire logic rd6 = REG_RD_IN && REG_ADDR_IN == 8'h06;
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (RESET_IN);
  property p_oe; sel |=> oe; endproperty
  a_oe: assert property (p_oe) else $error("oe low");
  property p_slv; !sel |=> !oe && !f && !b; endproperty
  a_slv: assert property (p_slv) else $error("slave pins");
  property p_frm; $changed(f) && oe |-> $fell(b); endproperty
  a_frm: assert property (p_frm) else $error("frame edge");
  property p_bit; $changed(b) && oe |=> $stable(b) [*3]; endproperty
  a_bit: assert property (p_bit) else $error("bit glitch");
  property p_rd; rd6 |=> REG_RDATA_OUT[7:4] == 4'h0; endproperty
  a_rd: assert property (p_rd) else $error("high bits");
  property p_idl; !REG_RD_IN |=> REG_RDATA_OUT == 8'h00; endproperty
  a_idl: assert property (p_idl) else $error("idle data");
  property p_um; REG_RD_IN && !rd6 |=> REG_RDATA_OUT == 8'h00; endproperty
  a_um: assert property (p_um) else $error("unmapped");
  c_frm: cover property ($rose(f));
  c_off: cover property ($fell(oe));
  c_rd: cover property (rd6);
endmodule : pbclk_props
bind port_b_master_clock_gen pbclk_props props_u (
  .CLOCK_IN(CLOCK_IN),
  .RESET_IN(RESET_IN),
  .REG_ADDR_IN(REG_ADDR_IN),
  .REG_RD_IN(REG_RD_IN),
  .REG_RDATA_OUT(REG_RDATA_OUT),
  .PORT_B_MASTER_SELECT_IN(PORT_B_MASTER_SELECT_IN),
  .PORT_B_FRAME_CLOCK_OUT(PORT_B_FRAME_CLOCK_OUT),
  .PORT_B_FRAME_CLOCK_OE_OUT(PORT_B_FRAME_CLOCK_OE_OUT),
  .PORT_B_BIT_CLOCK_OUT(PORT_B_BIT_CLOCK_OUT)
);

/* pbclk_sync.sv */
// Two flip-flop synchroniser for the three master clock pins.
// Assumes the inputs are asynchronous to clk_in.
`timescale 1ns/100ps

module pbclk_sync (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Data
  input wire logic [2:0] d_in,
  output logic [2:0] q_out
);

  logic [2:0] meta_ff;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_ff <= 3'h0;
      q_out <= 3'h0;
    end else begin
      meta_ff <= d_in;
      q_out <= meta_ff;
    end
  end

endmodule : pbclk_sync

/* port_b_master_clock_gen.sv */
// Port B frame and bit clock generator with its clock control register.
// Assumes master clocks well below half of CLOCK_IN, and a master select
// level driven from logic on CLOCK_IN.
`timescale 1ns/100ps
`include "pbclk_params.svh"

// Notes on behaviour
// - Frame clock divides master clock by 128/256/384/512.
// - Bit clock runs at sixty-four times frame clock.
// - Source field picks main, receiver or recovered clock.
// - Divider and source matter only in master mode.
// - Master select defaults slave; slave means external clocks.
// - Control register: bits 7:4 zero, source, divider.
module port_b_master_clock_gen (
  // Clock and reset
  input wire logic CLOCK_IN,
  input wire logic RESET_IN,
  // Register port
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [7:0] REG_RDATA_OUT,
  // Mode and master clock pins
  input wire logic PORT_B_MASTER_SELECT_IN,
  input wire logic MAIN_MCLK_IN,
  input wire logic RECEIVER_CLOCK_IN,
  input wire logic RECOVERED_RECEIVER_CLOCK_OUT_IN,
  // Port B clock pins
  output logic PORT_B_FRAME_CLOCK_OUT,
  output logic PORT_B_FRAME_CLOCK_OE_OUT,
  output logic PORT_B_BIT_CLOCK_OUT,
  output logic PORT_B_BIT_CLOCK_OE_OUT
);
  import pbclk_pkg::*;

  // Master clock edges between bit clock toggles: 1, 2, 3 or 4.
  function automatic logic [1:0] half_bit_last(input frame_div_e d);
    case (d)
      DIV_128: half_bit_last = 2'h0;
      DIV_256: half_bit_last = 2'h1;
      DIV_384: half_bit_last = 2'h2;
      DIV_512: half_bit_last = 2'h3;
      default: half_bit_last = 2'h0;
    endcase
  endfunction : half_bit_last

  // Rising edge of the chosen pin; the reserved code chooses none.
  function automatic logic pick_rise(input mclk_src_e s,
                                     input logic [2:0] r);
    case (s)
      SRC_MAIN_MCLK: pick_rise = r[0];
      SRC_RX_CLK_IN: pick_rise = r[1];
      SRC_RX_CLK_RECOVERED: pick_rise = r[2];
      default: pick_rise = 1'b0;
    endcase
  endfunction : pick_rise

  frame_div_e div_ff;
  mclk_src_e src_ff;
  gen_state_e state_ff;
  gen_state_e nxt_state;
  logic [2:0] mclk_sync;
  logic [2:0] mclk_sync_d_ff;
  logic [2:0] mclk_rises;
  logic mclk_rise;
  logic gen_run;
  logic gen_next;
  logic [1:0] half_last;
  logic [1:0] half_cnt_ff;
  logic [1:0] nxt_half_cnt;
  logic [4:0] bit_half_cnt_ff;
  logic [4:0] nxt_bit_half_cnt;
  logic half_wrap;
  logic bit_fall;
  logic frame_toggle;
  logic wr_ctrl;
  logic rd_ctrl;
  logic [7:0] ctrl_view;
  logic [7:0] nxt_rdata;
  logic nxt_bit;
  logic nxt_frame;
  logic nxt_oe;

  // The pins are free-running foreign clocks, so each is synchronised first.
  pbclk_sync u_sync (
    .clk_in(CLOCK_IN),
    .rst_in(RESET_IN),
    .d_in({RECOVERED_RECEIVER_CLOCK_OUT_IN, RECEIVER_CLOCK_IN,
           MAIN_MCLK_IN}),
    .q_out(mclk_sync)
  );

  assign wr_ctrl = REG_WR_IN && (REG_ADDR_IN == `PBCLK_REG_CLOCK_CONTROL);
  assign rd_ctrl = REG_RD_IN && (REG_ADDR_IN == `PBCLK_REG_CLOCK_CONTROL);
  assign ctrl_view = {4'h0, src_ff, div_ff};
  assign nxt_rdata = rd_ctrl ? ctrl_view : 8'h0;

  // Edges are found on every pin, so a source switch gives no false edge.
  assign mclk_rises = mclk_sync & ~mclk_sync_d_ff;
  // Reserved source code gives no edges, so the generator holds still.
  assign mclk_rise = pick_rise(src_ff, mclk_rises);

  assign nxt_state = PORT_B_MASTER_SELECT_IN ? GEN_RUN : GEN_IDLE;
  assign gen_run = (state_ff == GEN_RUN);
  assign gen_next = (nxt_state == GEN_RUN);
  assign nxt_oe = gen_next;

  assign half_last = half_bit_last(div_ff);
  assign half_wrap = gen_run && mclk_rise && (half_cnt_ff == half_last);
  assign nxt_half_cnt = !gen_run ? 2'h0 :
                        half_wrap ? 2'h0 :
                        mclk_rise ? half_cnt_ff + 2'h1 : half_cnt_ff;

  // A falling bit clock edge happens when a wrap meets a high bit clock.
  assign bit_fall = half_wrap && PORT_B_BIT_CLOCK_OUT;
  // Thirty-two bit clocks per frame half keeps the 64:1 ratio.
  assign frame_toggle = bit_fall &&
                        (bit_half_cnt_ff == `PBCLK_BIT_HALF_LAST);
  assign nxt_bit_half_cnt = (state_ff != GEN_RUN) ? 5'h0 :
                            bit_fall ? bit_half_cnt_ff + 5'h1 :
                            bit_half_cnt_ff;

  // Clocks drop with the enables, so a released pin holds no stale high.
  assign nxt_bit = !gen_next ? 1'b0 :
                   half_wrap ? !PORT_B_BIT_CLOCK_OUT :
                   PORT_B_BIT_CLOCK_OUT;
  assign nxt_frame = !gen_next ? 1'b0 :
                     frame_toggle ? !PORT_B_FRAME_CLOCK_OUT :
                     PORT_B_FRAME_CLOCK_OUT;

  always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      div_ff <= frame_div_e'(`PBCLK_DIV_RESET);
    end else if (wr_ctrl) begin
      div_ff <= frame_div_e'(REG_WDATA_IN[`PBCLK_DIV_MSB:`PBCLK_DIV_LSB]);
    end
  end

  // A reserved source code is kept, so it reads back as written.
  always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      src_ff <= mclk_src_e'(`PBCLK_SRC_RESET);
    end else if (wr_ctrl) begin
      src_ff <= mclk_src_e'(REG_WDATA_IN[`PBCLK_SRC_MSB:`PBCLK_SRC_LSB]);
    end
  end

  always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      REG_RDATA_OUT <= 8'h0;
    end else begin
      REG_RDATA_OUT <= nxt_rdata;
    end
  end

  // The run state follows master select one cycle late.
  always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      state_ff <= GEN_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      mclk_sync_d_ff <= 3'h0;
    end else begin
      mclk_sync_d_ff <= mclk_sync;
    end
  end

  // In slave mode counters clear and pins are released to the far end.
  always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      half_cnt_ff <= 2'h0;
    end else begin
      half_cnt_ff <= nxt_half_cnt;
    end
  end

  always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      bit_half_cnt_ff <= 5'h0;
    end else begin
      bit_half_cnt_ff <= nxt_bit_half_cnt;
    end
  end

  // Bit and frame pins move on one edge, so the pair stays locked.
  always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      PORT_B_BIT_CLOCK_OUT <= 1'b0;
    end else begin
      PORT_B_BIT_CLOCK_OUT <= nxt_bit;
    end
  end

  always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      PORT_B_FRAME_CLOCK_OUT <= 1'b0;
    end else begin
      PORT_B_FRAME_CLOCK_OUT <= nxt_frame;
    end
  end

  // Enables follow master select, so a slave port leaves the pins free.
  always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      PORT_B_BIT_CLOCK_OE_OUT <= 1'b0;
    end else begin
      PORT_B_BIT_CLOCK_OE_OUT <= nxt_oe;
    end
  end

  always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      PORT_B_FRAME_CLOCK_OE_OUT <= 1'b0;
    end else begin
      PORT_B_FRAME_CLOCK_OE_OUT <= nxt_oe;
    end
  end

endmodule : port_b_master_clock_gen

/* test_port_b_master_clock_gen.sv */
// Testbench for the port B master clock generator.
// Assumes pbclk_far_end supplies master clocks and counts frames and the bit clocks in each high frame half.
`timescale 1ns/100ps
module test_port_b_master_clock_gen;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, sel = 1'b0, q;
  logic [7:0] adr = 8'h00, wd = 8'h00, m;
  wire logic [7:0] rdat, hi, nf;
  wire logic [2:0] mck;
  wire logic f, foe, b, boe;
  int errors = 0, total_checks = 0, n, i;
  always #5 clk = ~clk;
  port_b_master_clock_gen dut_u (.CLOCK_IN(clk), .RESET_IN(rst),
    .REG_ADDR_IN(adr), .REG_WDATA_IN(wd), .REG_WR_IN(wr), .REG_RD_IN(rd),
    .REG_RDATA_OUT(rdat), .PORT_B_MASTER_SELECT_IN(sel),
    .MAIN_MCLK_IN(mck[0]), .RECEIVER_CLOCK_IN(mck[1]),
    .RECOVERED_RECEIVER_CLOCK_OUT_IN(mck[2]), .PORT_B_FRAME_CLOCK_OUT(f),
    .PORT_B_FRAME_CLOCK_OE_OUT(foe), .PORT_B_BIT_CLOCK_OUT(b),
    .PORT_B_BIT_CLOCK_OE_OUT(boe));
  pbclk_far_end far_u (.frame_in(f), .bit_in(b), .oe_in(foe),
    .mclk_out(mck), .hi_out(hi), .frames_out(nf));
  task end_sim;
    $display("errors=%0d checks=%0d", errors, total_checks);
    if (errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  task chk(string nm, logic [15:0] s, logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  // One strobed access; read data is checked in the cycle it stands.
  task acc(logic w, logic [7:0] a, logic [7:0] d, logic [7:0] e);
    wr = w;
    rd = !w;
    adr = a;
    wd = d;
    @(negedge clk);
    wr = 1'b0;
    rd = 1'b0;
    if (!w) chk("rdata", 16'(rdat), 16'(e));
    @(negedge clk);
  endtask : acc
  task rise(output int k);
    logic p;
    k = 0;
    do begin
      p = b;
      @(negedge clk);
      k++;
    end while (!(p === 1'b0 && b === 1'b1) && k < 3000);
    if (k >= 3000) begin
      errors++;
      end_sim;
    end
  endtask : rise
  initial begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    acc(0, 8'h06, 8'h00, 8'h00);
    acc(0, 8'h07, 8'h00, 8'h00);
    acc(1, 8'h06, 8'hff, 8'h00);
    acc(0, 8'h06, 8'h00, 8'h0f);
    sel = 1'b1;
    @(negedge clk);
    chk("oe", 16'({foe, boe}), 16'h3);
    for (int s = 0; s < 3; s++) begin
      for (int d = 0; d < 4; d++) begin
        // A write right after a bit clock edge may cut that half short.
        repeat (2) @(negedge clk);
        acc(1, 8'h06, 8'(s * 4 + d), 8'h00);
        rise(n);
        rise(n);
        chk("bit_period", 16'(n), 16'((d + 1) * (20 + 8 * s)));
      end
    end
    repeat (2) @(negedge clk);
    acc(1, 8'h06, 8'h00, 8'h00);
    m = nf;
    for (i = 0; nf !== m + 8'h02 && i < 20000; i++) @(negedge clk);
    if (i >= 20000) begin
      errors++;
      end_sim;
    end
    chk("half_frame", 16'(hi), 16'h20);
    // Reserved source must freeze the clocks; let synced edges drain.
    acc(1, 8'h06, 8'h0c, 8'h00);
    repeat (5) @(negedge clk);
    q = b;
    n = 0;
    for (i = 0; i < 300; i++) begin
      @(negedge clk);
      if (b !== q) n++;
    end
    chk("frozen", 16'(n), 16'h0);
    sel = 1'b0;
    repeat (2) @(negedge clk);
    chk("slave", 16'({foe, boe, f, b}), 16'h0);
    end_sim;
  end
endmodule : test_port_b_master_clock_gen
